/* core/bit_skip_map.svh */
// Purpose: Offsets, field positions and reset values of the bit and skip unit
// Assumes: Included by its bare name
// Notes:   Definitions only
`ifndef BIT_SKIP_MAP_SVH
`define BIT_SKIP_MAP_SVH
// IO space: flag register, port A data latch, port A direction
`define IO_FLAGS     2'h0
`define IO_PORTA     2'h1
`define IO_PORTA_DIR 2'h2
// Flag register bit positions
`define FLAG_Z       0
`define FLAG_C       1
`define FLAG_AC      2
`define FLAG_OV      3
`define FLAGS_RST    4'h0
`define BYTE_RST     8'h00
`define BYTE_ONE     8'h01
`define NIB_CARRY    4
`define BYTE_CARRY   8
`define BYTE_MSB     7
`endif

/* core/bit_skip_pkg.sv */
// Purpose: Types shared by the bit and skip unit and its bench
// Assumes: Nothing
// Notes:   Operation codes carry no fixed encoding
package bit_skip_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [4:0] {
    OP_NOP,
    OP_LOAD_ACC,
    OP_STORE_MEM,
    OP_CLEAR_BIT_IO,
    OP_RAISE_BIT_IO,
    OP_SWAP_CARRY_IO,
    OP_CLEAR_BIT_MEM,
    OP_RAISE_BIT_MEM,
    OP_CEQ_IMM,
    OP_CEQ_MEM,
    OP_CNE_IMM,
    OP_CNE_MEM,
    OP_SKIP_IF_BIT_LOW_IO,
    OP_SKIP_IF_BIT_HIGH_IO,
    OP_SKIP_IF_BIT_LOW_MEM,
    OP_SKIP_IF_BIT_HIGH_MEM,
    OP_INC_ACC,
    OP_DEC_ACC,
    OP_INC_MEM,
    OP_DEC_MEM
  } op_e;
endpackage

/* core/bit_skip_unit.sv */
// Purpose: Bit set/clear/swap and conditional skip execution for an 8-bit core
// Assumes: One instruction offered per cycle on op_valid_i, single clock
// Notes:   Each instruction executes in the cycle it is taken
`timescale 1ns/10ps
`include "bit_skip_map.svh"

// Overview of operation
// - Clear-bit on IO zeroes bit n only; flags unchanged unless the flag register is the target.
// - Raise-bit on IO sets bit n only; flags unchanged unless the flag register is the target.
// - Carry exchange swaps a port A or direction bit with carry; on the flag register it only loads bit n into carry.
// - Output pin: carry exchange drives old carry onto the port bit.
// - Input pin: carry exchange loads sampled pin level into carry.
// - Direction bit 1 makes the pin an output, 0 an input.
// - Carry sits at bit 1 of the flag register, writable directly.
// - Clear-bit on memory zeroes bit n; flags unchanged.
// - Raise-bit on memory sets bit n; flags unchanged.
// - Compare-equal skips next instruction when accumulator equals operand.
// - Compare-skips set all four flags as accumulator minus operand.
// - Compare-unequal skips next instruction when accumulator differs.
// - Test-low skips when the IO or memory bit is 0; no flags.
// - Test-high skips when the IO or memory bit is 1; no flags.
// - Increment accumulator, set all flags, skip on zero result.
// - Decrement accumulator, set all flags, skip on zero result.
// - Increment memory byte, write back, set flags, skip on zero.
// - Decrement memory byte, write back, set flags, skip on zero.
module bit_skip_unit #(
  parameter int MEM_DEPTH = 16,
  parameter int MEM_AW    = 4
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  arst_n_i,
  // Instruction
  input  wire logic                  op_valid_i,
  input  wire bit_skip_pkg::op_e     op_i,
  input  wire logic [2:0]            bit_sel_i,
  input  wire logic [1:0]            io_addr_i,
  input  wire logic [MEM_AW-1:0]     mem_addr_i,
  input  wire bit_skip_pkg::byte_t   imm_i,
  // Port A pins
  input  wire bit_skip_pkg::byte_t   port_a_pin_i,
  output logic [7:0]                 port_a_data_o,
  output logic [7:0]                 port_a_oe_n_o,
  // Core state
  output logic [7:0]                 working_register_o,
  output logic [3:0]                 flags_o,
  input  wire logic [MEM_AW-1:0]     peek_addr_i,
  output logic [7:0]                 peek_data_o,
  // Skip status
  output logic                       skip_pending_o,
  output logic                       discard_o
);
  import bit_skip_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  byte_t      working_register;
  logic [3:0] flags;
  byte_t      port_a_data;
  byte_t      port_a_dir;
  byte_t      pin_meta;
  byte_t      pin_sync;
  byte_t      mem [MEM_DEPTH];
  logic       skip_pending;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Returns {flags, result} for a+b or a-b; carry is borrow on subtract
  function automatic logic [11:0] arith(input byte_t a, input byte_t b, input logic sub);
    logic [8:0] full;
    logic [4:0] low;
    logic [3:0] f;
    full = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
    low  = sub ? ({1'b0, a[3:0]} - {1'b0, b[3:0]}) : ({1'b0, a[3:0]} + {1'b0, b[3:0]});
    f[`FLAG_Z]  = (full[7:0] == `BYTE_RST);
    f[`FLAG_C]  = full[`BYTE_CARRY];
    f[`FLAG_AC] = low[`NIB_CARRY];
    f[`FLAG_OV] = ((a[`BYTE_MSB] ^ b[`BYTE_MSB]) == sub) &&
                  (full[`BYTE_MSB] != a[`BYTE_MSB]);
    return {f, full[7:0]};
  endfunction

  // Input pins read the synchronised level, output pins the latch
  function automatic byte_t io_read(input logic [1:0] addr, input logic [3:0] fl,
                                    input byte_t dat, input byte_t dir, input byte_t pin);
    case (addr)
      `IO_FLAGS:     io_read = {4'h0, fl};
      `IO_PORTA:     io_read = (dat & dir) | (pin & ~dir);
      `IO_PORTA_DIR: io_read = dir;
      default:       io_read = `BYTE_RST;
    endcase
  endfunction

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic        exec;
  byte_t       io_val;
  byte_t       mem_val;
  byte_t       cmp_op;
  logic [11:0] cmp_res;
  logic [11:0] step_res;
  logic        is_cmp;
  logic        is_step;
  logic        step_mem;
  logic        next_skip;

  assign exec    = op_valid_i && !skip_pending;
  assign io_val  = io_read(io_addr_i, flags, port_a_data, port_a_dir, pin_sync);
  assign mem_val = mem[mem_addr_i];

  always_comb
  begin
    is_cmp   = 1'b0;
    is_step  = 1'b0;
    step_mem = 1'b0;
    cmp_op   = imm_i;
    case (op_i)
      OP_CEQ_IMM, OP_CNE_IMM: is_cmp = 1'b1;
      OP_CEQ_MEM, OP_CNE_MEM:
      begin
        is_cmp = 1'b1;
        cmp_op = mem_val;
      end
      OP_INC_ACC, OP_DEC_ACC: is_step = 1'b1;
      OP_INC_MEM, OP_DEC_MEM:
      begin
        is_step  = 1'b1;
        step_mem = 1'b1;
      end
      default: is_cmp = 1'b0;
    endcase
  end

  // Compare is a subtraction whose result is dropped
  assign cmp_res  = arith(working_register, cmp_op, 1'b1);
  assign step_res = arith(step_mem ? mem_val : working_register, `BYTE_ONE,
                          (op_i == OP_DEC_ACC) || (op_i == OP_DEC_MEM));

  always_comb
  begin
    case (op_i)
      OP_CEQ_IMM, OP_CEQ_MEM: next_skip = (working_register == cmp_op);
      OP_CNE_IMM, OP_CNE_MEM: next_skip = (working_register != cmp_op);
      OP_SKIP_IF_BIT_LOW_IO:   next_skip = !io_val[bit_sel_i];
      OP_SKIP_IF_BIT_HIGH_IO:  next_skip = io_val[bit_sel_i];
      OP_SKIP_IF_BIT_LOW_MEM:  next_skip = !mem_val[bit_sel_i];
      OP_SKIP_IF_BIT_HIGH_MEM: next_skip = mem_val[bit_sel_i];
      OP_INC_ACC, OP_DEC_ACC, OP_INC_MEM, OP_DEC_MEM:
        next_skip = (step_res[7:0] == `BYTE_RST);
      default: next_skip = 1'b0;
    endcase
  end

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      pin_meta <= `BYTE_RST;
      pin_sync <= `BYTE_RST;
    end
    else
    begin
      pin_meta <= port_a_pin_i;
      pin_sync <= pin_meta;
    end

  // ****************************************************************
  // Skip tracking
  // ****************************************************************
  // The next offered instruction after a skip is consumed and dropped
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      skip_pending <= 1'b0;
      discard_o    <= 1'b0;
    end
    else
    begin
      discard_o <= op_valid_i && skip_pending;
      if (exec)
        skip_pending <= next_skip;
      else if (op_valid_i)
        skip_pending <= 1'b0;
    end

  // ****************************************************************
  // Working register
  // ****************************************************************
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
      working_register <= `BYTE_RST;
    else if (exec && op_i == OP_LOAD_ACC)
      working_register <= imm_i;
    else if (exec && is_step && !step_mem)
      working_register <= step_res[7:0];

  // ****************************************************************
  // Flag register
  // ****************************************************************
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
      flags <= `FLAGS_RST;
    else if (exec)
    begin
      if (is_cmp)
        flags <= cmp_res[11:8];
      else if (is_step)
        flags <= step_res[11:8];
      else if (op_i == OP_SWAP_CARRY_IO)
        flags[`FLAG_C] <= io_val[bit_sel_i];
      else if (io_addr_i == `IO_FLAGS && op_i == OP_CLEAR_BIT_IO && bit_sel_i <= 3'h3)
        flags[bit_sel_i[1:0]] <= 1'b0;
      else if (io_addr_i == `IO_FLAGS && op_i == OP_RAISE_BIT_IO && bit_sel_i <= 3'h3)
        flags[bit_sel_i[1:0]] <= 1'b1;
    end

  // ****************************************************************
  // Port A latch and direction
  // ****************************************************************
  // Swap writes the latch even on an input pin so that a later
  // direction change drives the value last exchanged
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
      port_a_data <= `BYTE_RST;
    else if (exec && io_addr_i == `IO_PORTA)
    begin
      if (op_i == OP_CLEAR_BIT_IO)
        port_a_data[bit_sel_i] <= 1'b0;
      else if (op_i == OP_RAISE_BIT_IO)
        port_a_data[bit_sel_i] <= 1'b1;
      else if (op_i == OP_SWAP_CARRY_IO)
        port_a_data[bit_sel_i] <= flags[`FLAG_C];
    end

  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
      port_a_dir <= `BYTE_RST;
    else if (exec && io_addr_i == `IO_PORTA_DIR)
    begin
      if (op_i == OP_CLEAR_BIT_IO)
        port_a_dir[bit_sel_i] <= 1'b0;
      else if (op_i == OP_RAISE_BIT_IO)
        port_a_dir[bit_sel_i] <= 1'b1;
      else if (op_i == OP_SWAP_CARRY_IO)
        port_a_dir[bit_sel_i] <= flags[`FLAG_C];
    end

  // ****************************************************************
  // Data memory
  // ****************************************************************
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      for (int i = 0; i < MEM_DEPTH; i++)
        mem[i] <= `BYTE_RST;
    end
    else if (exec)
    begin
      case (op_i)
        OP_STORE_MEM:     mem[mem_addr_i] <= working_register;
        OP_CLEAR_BIT_MEM: mem[mem_addr_i][bit_sel_i] <= 1'b0;
        OP_RAISE_BIT_MEM: mem[mem_addr_i][bit_sel_i] <= 1'b1;
        OP_INC_MEM, OP_DEC_MEM: mem[mem_addr_i] <= step_res[7:0];
        default: ;
      endcase
    end

  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
      peek_data_o <= `BYTE_RST;
    else
      peek_data_o <= mem[peek_addr_i];

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign working_register_o = working_register;
  assign flags_o            = flags;
  assign port_a_data_o      = port_a_data;
  assign port_a_oe_n_o      = ~port_a_dir;
  assign skip_pending_o     = skip_pending;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  io_clear_bit_a: assert property (exec && op_i == OP_CLEAR_BIT_IO
    && io_addr_i == `IO_PORTA |=> !port_a_data[$past(bit_sel_i)] && flags == $past(flags))
    else $error("IO clear-bit failed");
  io_raise_bit_a: assert property (exec && op_i == OP_RAISE_BIT_IO
    && io_addr_i == `IO_PORTA |=> port_a_data[$past(bit_sel_i)] && flags == $past(flags))
    else $error("IO raise-bit failed");
  swap_out_a: assert property (exec && op_i == OP_SWAP_CARRY_IO
    && io_addr_i == `IO_PORTA && port_a_dir[bit_sel_i] |=> !port_a_oe_n_o[$past(bit_sel_i)]
    && port_a_data[$past(bit_sel_i)] == $past(flags[`FLAG_C]))
    else $error("Carry not driven to output pin");
  swap_in_a: assert property (exec && op_i == OP_SWAP_CARRY_IO
    && io_addr_i == `IO_PORTA && !port_a_dir[bit_sel_i]
    |=> flags[`FLAG_C] == $past(pin_sync[bit_sel_i]) && flags[`FLAG_Z] == $past(flags[`FLAG_Z])
    && flags[`FLAG_OV] == $past(flags[`FLAG_OV]) && flags[`FLAG_AC] == $past(flags[`FLAG_AC]))
    else $error("Pin level not loaded into carry");
  mem_bit_a: assert property (exec && op_i == OP_CLEAR_BIT_MEM
    |=> !mem[$past(mem_addr_i)][$past(bit_sel_i)] && flags == $past(flags))
    else $error("Memory clear-bit failed");
  cmp_equal_a: assert property (exec && (op_i == OP_CEQ_IMM || op_i == OP_CEQ_MEM)
    |=> skip_pending == $past(working_register == cmp_op)
    && flags[`FLAG_Z] == skip_pending)
    else $error("Compare-equal skip wrong");
  cmp_unequal_a: assert property (exec && (op_i == OP_CNE_IMM || op_i == OP_CNE_MEM)
    |=> skip_pending == !flags[`FLAG_Z])
    else $error("Compare-unequal skip wrong");
  test_bit_a: assert property (exec && op_i == OP_SKIP_IF_BIT_HIGH_MEM
    |=> skip_pending == $past(mem_val[bit_sel_i]) && $stable(flags))
    else $error("Bit test skip wrong");
  inc_acc_a: assert property (exec && op_i == OP_INC_ACC
    |=> working_register == 8'($past(working_register) + `BYTE_ONE)
    && skip_pending == (working_register == `BYTE_RST))
    else $error("Increment-and-skip wrong");
  dec_mem_a: assert property (exec && op_i == OP_DEC_MEM
    |=> mem[$past(mem_addr_i)] == 8'($past(mem_val) - `BYTE_ONE)
    && skip_pending == flags[`FLAG_Z])
    else $error("Decrement memory wrong");
  discard_a: assert property (op_valid_i && skip_pending
    |=> discard_o && !skip_pending && $stable(flags) && $stable(working_register)
    && $stable(port_a_data))
    else $error("Skipped instruction had effect");

  cmp_skip_c: cover property (exec && op_i == OP_CEQ_MEM && next_skip ##1 op_valid_i);
  swap_in_c:  cover property (exec && op_i == OP_SWAP_CARRY_IO && !port_a_dir[bit_sel_i]);
  dec_zero_c: cover property (exec && op_i == OP_DEC_MEM && next_skip);
endmodule

/* tb/bit_skip_unit_tb.sv */
// Purpose: Self-checking bench for the bit and skip unit
// Assumes: Pins change only in idle gaps of 3 cycles, so the synchroniser has settled
// Notes:   A reference model beside the driver queues one note per offered instruction
`timescale 1ns/10ps
module bit_skip_unit_tb;
  import bit_skip_pkg::*;
  typedef struct {byte_t acc; logic [3:0] flg; byte_t port; byte_t oe_n;
                  logic skip; logic disc; byte_t memv;} note_s;
  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        op_valid_i = 1'b0;
  op_e         op_i = OP_NOP;
  logic [2:0]  bit_sel_i = 3'h0;
  logic [1:0]  io_addr_i = 2'h0;
  logic [3:0]  mem_addr_i = 4'h0;
  logic [3:0]  peek_addr_i = 4'h0;
  byte_t       imm_i = 8'h00;
  byte_t       port_a_pin_i = 8'h00;
  logic [7:0]  port_a_data_o, port_a_oe_n_o, working_register_o, peek_data_o;
  logic [3:0]  flags_o;
  logic        skip_pending_o, discard_o;
  int          bad_count = 0;
  int          n_checks = 0;
  integer      seed = 32'hc541;
  note_s       notes[$];
  note_s       cur;
  logic        take = 1'b0;
  logic        peek_pend = 1'b0;
  byte_t       peek_exp;
  // Reference state
  byte_t       m_acc, m_port, m_dir, m_pin;
  byte_t       m_mem[16];
  logic [3:0]  m_flags, prev_ma;
  logic        m_skip;

  bit_skip_unit #(.MEM_DEPTH(16), .MEM_AW(4)) i_bit_skip_unit (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .op_valid_i(op_valid_i), .op_i(op_i),
    .bit_sel_i(bit_sel_i), .io_addr_i(io_addr_i), .mem_addr_i(mem_addr_i), .imm_i(imm_i),
    .port_a_pin_i(port_a_pin_i), .port_a_data_o(port_a_data_o),
    .port_a_oe_n_o(port_a_oe_n_o), .working_register_o(working_register_o),
    .flags_o(flags_o), .peek_addr_i(peek_addr_i), .peek_data_o(peek_data_o),
    .skip_pending_o(skip_pending_o), .discard_o(discard_o));

  initial forever #4 clk_i = ~clk_i;

  // ************************************************************
  // Checking and closing
  // ************************************************************
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    tally_and_finish();
  end

  always @(posedge clk_i)
  begin
    take = arst_n_i && (op_valid_i === 1'b1);
    if (take && notes.size() == 0)
    begin
      take = 1'b0;
      check("note queue", 8'h00, 8'h01);
    end
    else if (take)
      cur = notes.pop_front();
  end

  // Peek lags one cycle more, so its note is held over to the next falling edge
  always @(negedge clk_i)
  begin
    if (peek_pend)
      check("peek", peek_data_o, peek_exp);
    peek_pend = take;
    if (take)
    begin
      peek_exp = cur.memv;
      check("acc", working_register_o, cur.acc);
      check("flags", {4'h0, flags_o}, {4'h0, cur.flg});
      check("port", port_a_data_o, cur.port);
      check("oe_n", port_a_oe_n_o, cur.oe_n);
      check("skip", {7'h0, skip_pending_o}, {7'h0, cur.skip});
      check("discard", {7'h0, discard_o}, {7'h0, cur.disc});
    end
  end

  // ************************************************************
  // Driver with reference model
  // ************************************************************
  function automatic logic [11:0] arith(input byte_t a, input byte_t b, input logic sub);
    logic [8:0] r;
    logic       h;
    r = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    h = sub ? (a[3:0] < b[3:0]) : ({1'b0, a[3:0]} + {1'b0, b[3:0]} > 5'h0F);
    return {(a[7] ^ b[7] ^ ~sub) & (a[7] ^ r[7]), h, r[8], r[7:0] == 8'h00, r[7:0]};
  endfunction

  task automatic wr_io(input logic [1:0] io, input logic [2:0] n, input logic v);
    if (io == 2'h0 && n < 3'h4)
      m_flags[n[1:0]] = v;
    else if (io == 2'h1)
      m_port[n] = v;
    else if (io == 2'h2)
      m_dir[n] = v;
  endtask

  task automatic idle(input int k);
    repeat (k)
    begin
      @(negedge clk_i);
      op_valid_i = 1'b0;
      peek_addr_i = prev_ma;
    end
  endtask

  task automatic issue(input op_e op, input logic [2:0] n, input logic [1:0] io,
                       input logic [3:0] ma, input byte_t imm);
    byte_t       rd;
    logic [11:0] ar;
    logic        sk;
    logic        oc;
    note_s       nt;
    @(negedge clk_i);
    op_valid_i = 1'b1;
    op_i = op;
    bit_sel_i = n;
    io_addr_i = io;
    mem_addr_i = ma;
    imm_i = imm;
    peek_addr_i = prev_ma;
    rd = io == 2'h0 ? {4'h0, m_flags} : io == 2'h1 ? (m_port & m_dir) | (m_pin & ~m_dir) :
         io == 2'h2 ? m_dir : 8'h00;
    nt.disc = m_skip;
    sk = 1'b0;
    if (!m_skip)
      case (op)
        OP_LOAD_ACC: m_acc = imm;
        OP_STORE_MEM: m_mem[ma] = m_acc;
        OP_CLEAR_BIT_IO, OP_RAISE_BIT_IO: wr_io(io, n, op == OP_RAISE_BIT_IO);
        OP_SWAP_CARRY_IO:
        begin
          oc = m_flags[1];
          m_flags[1] = rd[n];
          if (io != 2'h0)
            wr_io(io, n, oc);
        end
        OP_CLEAR_BIT_MEM, OP_RAISE_BIT_MEM: m_mem[ma][n] = op == OP_RAISE_BIT_MEM;
        OP_CEQ_IMM, OP_CEQ_MEM, OP_CNE_IMM, OP_CNE_MEM:
        begin
          ar = arith(m_acc, (op == OP_CEQ_MEM || op == OP_CNE_MEM) ? m_mem[ma] : imm, 1'b1);
          m_flags = ar[11:8];
          sk = ar[8] ^ (op == OP_CNE_IMM || op == OP_CNE_MEM);
        end
        OP_SKIP_IF_BIT_LOW_IO: sk = !rd[n];
        OP_SKIP_IF_BIT_HIGH_IO: sk = rd[n];
        OP_SKIP_IF_BIT_LOW_MEM: sk = !m_mem[ma][n];
        OP_SKIP_IF_BIT_HIGH_MEM: sk = m_mem[ma][n];
        OP_INC_ACC, OP_DEC_ACC:
        begin
          ar = arith(m_acc, 8'h01, op == OP_DEC_ACC);
          {m_flags, m_acc} = ar;
          sk = ar[8];
        end
        OP_INC_MEM, OP_DEC_MEM:
        begin
          ar = arith(m_mem[ma], 8'h01, op == OP_DEC_MEM);
          {m_flags, m_mem[ma]} = ar;
          sk = ar[8];
        end
        default: ;
      endcase
    m_skip = sk;
    nt.acc = m_acc;
    nt.flg = m_flags;
    nt.port = m_port;
    nt.oe_n = ~m_dir;
    nt.skip = m_skip;
    nt.memv = m_mem[ma];
    notes.push_back(nt);
    prev_ma = ma;
  endtask

  task automatic do_reset();
    idle(2);
    arst_n_i = 1'b0;
    m_acc = 8'h00;
    m_port = 8'h00;
    m_dir = 8'h00;
    m_flags = 4'h0;
    m_skip = 1'b0;
    prev_ma = 4'h0;
    foreach (m_mem[i]) m_mem[i] = 8'h00;
    repeat (10) @(negedge clk_i);
    check("rst acc", working_register_o, 8'h00);
    check("rst oe_n", port_a_oe_n_o, 8'hFF);
    check("rst flags", {flags_o, port_a_data_o[3:0]}, 8'h00);
    check("rst port", port_a_data_o, 8'h00);
    check("rst skip", {6'h0, skip_pending_o, discard_o}, 8'h00);
    arst_n_i = 1'b1;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial
  begin
    m_pin = 8'h00;
    do_reset();
    // Skip survives idle cycles and the discarded store leaves memory alone
    issue(OP_LOAD_ACC, 3'h0, 2'h0, 4'h2, 8'h5A);
    issue(OP_CEQ_IMM, 3'h0, 2'h0, 4'h2, 8'h5A);
    issue(OP_INC_ACC, 3'h0, 2'h0, 4'h2, 8'h00);
    issue(OP_CNE_MEM, 3'h0, 2'h0, 4'h2, 8'h00);
    idle(3);
    issue(OP_STORE_MEM, 3'h0, 2'h0, 4'h2, 8'h00);
    issue(OP_CLEAR_BIT_IO, 3'h2, 2'h3, 4'h2, 8'h00);
    $display("test skip done");
    // Increment wrap FF to 00 on accumulator and memory; the decrement after it is skipped
    for (int k = 0; k < 4; k++)
      begin
        issue(OP_LOAD_ACC, 3'h0, 2'h0, 4'h3, k[0] ? 8'h80 : 8'hFF);
        issue(OP_STORE_MEM, 3'h0, 2'h0, 4'h3, 8'h00);
        issue(k[1] ? OP_INC_MEM : OP_INC_ACC, 3'h0, 2'h0, 4'h3, 8'h00);
        issue(k[1] ? OP_DEC_MEM : OP_DEC_ACC, 3'h0, 2'h0, 4'h3, 8'h00);
        issue(OP_NOP, 3'h0, 2'h0, 4'h3, 8'h00);
      end
    $display("test wrap done");
    // Mid-run reset, then a random stream over every operation code
    do_reset();
    for (int i = 0; i < 600; i++)
    begin
      if (i % 50 == 0)
      begin
        port_a_pin_i = 8'($random(seed));
        m_pin = port_a_pin_i;
        idle(3);
      end
      issue(op_e'(5'($unsigned($random(seed)) % 20)), 3'($random(seed)),
            2'($unsigned($random(seed)) % 3), 4'($random(seed)),
            ($random(seed) & 1) ? m_acc : 8'($random(seed)));
    end
    idle(3);
    $display("test random done");
    tally_and_finish();
  end
endmodule
